// File: rtl/iac_pkg.sv
// Shared constants, types and carriers for the interrupt acknowledge capture unit
package iac_pkg;

  // Host function addresses
  localparam logic [31:0] IAC_ADDR_INT_ENABLE = 32'hf0000080; // Write enable and clear
  localparam logic [31:0] IAC_ADDR_VEC_REARM = 32'hf0000082; // Read vector, rearm
  localparam logic [31:0] IAC_ADDR_VEC_PEEK = 32'hf0000084; // Read vector only
  localparam logic [31:0] IAC_ADDR_FORCE_ONCE = 32'hf0000086; // Forced sequence
  localparam logic [31:0] IAC_ADDR_FORCE_LOOP = 32'hf0000088; // Forced, repeating
  localparam logic [31:0] IAC_ADDR_CASC_LOW = 32'hf000008c; // Cascade low word
  localparam logic [31:0] IAC_ADDR_CASC_HIGH = 32'hf000008e; // Cascade top byte

  // Field layout and values
  localparam logic [15:0] IAC_ENABLE_VALUE = 16'h0001; // Value that enables
  localparam int IAC_VEC_W = 8; // Vector byte width
  localparam int IAC_CASC_W = 24; // Cascade address width
  localparam int IAC_DATA_W = 16; // Host and target data width
  localparam logic [7:0] IAC_VEC_RESET = 8'h00; // Vector after reset
  localparam logic [23:0] IAC_CASC_RESET = 24'h000000; // Cascade after reset
  localparam logic [15:0] IAC_RDATA_NONE = 16'h0000; // Unmapped read answer

  // Timing
  localparam int IAC_CLK_NS = 40; // Clock period
  localparam int IAC_ACK_CYC_NS = 80; // Least length of one acknowledge cycle
  localparam int IAC_ACK_GAP_NS = 120; // Least idle time between the two cycles
  localparam int IAC_ACK_CYC_CNT = (IAC_ACK_CYC_NS + IAC_CLK_NS - 1) / IAC_CLK_NS;
  localparam int IAC_ACK_GAP_CNT = (IAC_ACK_GAP_NS + IAC_CLK_NS - 1) / IAC_CLK_NS;
  localparam int IAC_CNT_W = 4; // Wait counter width
  localparam logic [3:0] IAC_CYC_LOAD = 4'(IAC_ACK_CYC_CNT - 1); // Cycle count load
  localparam logic [3:0] IAC_GAP_LOAD = 4'(IAC_ACK_GAP_CNT - 1); // Gap count load

  // Sequencer states
  typedef enum logic [2:0] {
    IAC_IDLE,
    IAC_CYC1,
    IAC_GAP,
    IAC_CYC2
  } iac_state_t;

  // Host request carrier
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [15:0] wdata;
  } iac_hreq_t;

  // Target bus sample carrier
  typedef struct packed {
    logic [15:0] data;
    logic [23:0] addr;
  } iac_tbus_t;

endpackage : iac_pkg

// File: rtl/iac_unit.sv
// Interrupt acknowledge, vector and cascade capture logic of the test pod
`timescale 1ns/1ps
module iac_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host function access
  input wire logic host_req,
  input wire iac_pkg::iac_hreq_t host_cmd,
  output logic host_ack,
  output logic [15:0] host_rdata,
  // Target board pins
  input wire logic interrupt_request_input,
  input wire logic tgt_ready_n,
  input wire iac_pkg::iac_tbus_t tgt_bus,
  output logic acknowledge_cycle_n,
  // Scope and mode
  input wire logic acknowledge_cycle_sync_sel,
  input wire logic emulation_run_mode,
  output logic scope_trig_n,
  output logic irq_to_cpu,
  output logic target_handler_sel,
  output logic pending_vector_flag
);
  import iac_pkg::*;

  // Pin synchronisers: three stages each, first stage read only by second
  logic [2:0] irq_sync; // Request pin stages
  logic [2:0] rdy_sync; // Ready pin stages
  logic irq_f; // Filtered request level
  logic rdy_f; // Filtered ready level, active high

  // Sequencer state
  iac_state_t state; // Acknowledge sequencer
  logic [3:0] wait_cnt; // Cycle length counter
  logic seq_last; // Final edge of the vector cycle
  logic seq_start; // Sequence begins this edge

  // Control flags
  logic int_en; // Target interrupts enabled
  logic armed; // Request input re-enabled
  logic force_pend; // Forced sequence waiting
  logic loop_on; // Forced sequence repeats
  logic ack_wait; // Host waits for forced vector

  // Captures
  logic [7:0] vector; // Captured vector byte
  logic [23:0] cascade; // Captured cascade address

  // Decoded host accesses
  logic wr_enable; // Write to the enable address
  logic rd_rearm; // Read of the rearming address
  logic rd_peek; // Read of the peek address
  logic rd_force; // Read of either force address
  logic rd_loop; // Read of the loop address
  logic rd_casc_lo; // Read of cascade low word
  logic rd_casc_hi; // Read of cascade top byte
  logic req_take; // Request accepted this edge

  // Host accesses only while no forced read is outstanding
  assign req_take = host_req && !ack_wait;
  assign wr_enable = req_take && host_cmd.wr && host_cmd.addr == IAC_ADDR_INT_ENABLE;
  assign rd_rearm = req_take && !host_cmd.wr && host_cmd.addr == IAC_ADDR_VEC_REARM;
  assign rd_peek = req_take && !host_cmd.wr && host_cmd.addr == IAC_ADDR_VEC_PEEK;
  assign rd_loop = req_take && !host_cmd.wr && host_cmd.addr == IAC_ADDR_FORCE_LOOP;
  assign rd_force = rd_loop ||
    (req_take && !host_cmd.wr && host_cmd.addr == IAC_ADDR_FORCE_ONCE);
  assign rd_casc_lo = req_take && !host_cmd.wr && host_cmd.addr == IAC_ADDR_CASC_LOW;
  assign rd_casc_hi = req_take && !host_cmd.wr && host_cmd.addr == IAC_ADDR_CASC_HIGH;

  // Synchronise request and ready pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_sync <= 3'h0;
      rdy_sync <= 3'h7;
    end else begin
      irq_sync <= {irq_sync[1:0], interrupt_request_input};
      rdy_sync <= {rdy_sync[1:0], tgt_ready_n};
    end
  end

  // Filtered levels change only when the last two stages agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_f <= 1'b0;
      rdy_f <= 1'b0;
    end else begin
      if (irq_sync[1] == irq_sync[2]) begin
        irq_f <= irq_sync[2];
      end
      if (rdy_sync[1] == rdy_sync[2]) begin
        rdy_f <= !rdy_sync[2];
      end
    end
  end

  // Start on force, loop, or an enabled and armed request
  assign seq_start = state == IAC_IDLE &&
    (force_pend || loop_on || (int_en && armed && irq_f));
  // Vector cycle ends once its least length passed and the target is ready
  assign seq_last = state == IAC_CYC2 && wait_cnt == 4'h0 && rdy_f;

  // Two-cycle acknowledge sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= IAC_IDLE;
      wait_cnt <= 4'h0;
      acknowledge_cycle_n <= 1'b1;
    end else begin
      case (state)
        IAC_IDLE: begin
          // First cycle opens the sequence
          if (seq_start) begin
            state <= IAC_CYC1;
            wait_cnt <= IAC_CYC_LOAD;
            acknowledge_cycle_n <= 1'b0;
          end
        end
        IAC_CYC1: begin
          // Count down, then wait for target ready
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (rdy_f) begin
            state <= IAC_GAP;
            wait_cnt <= IAC_GAP_LOAD;
            acknowledge_cycle_n <= 1'b1;
          end
        end
        IAC_GAP: begin
          // Idle gap so the target sees two distinct cycles; the gap also
          // lasts until the filtered ready of the first cycle has dropped,
          // else the vector cycle would end on a stale ready
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (!rdy_f) begin
            state <= IAC_CYC2;
            wait_cnt <= IAC_CYC_LOAD;
            acknowledge_cycle_n <= 1'b0;
          end
        end
        IAC_CYC2: begin
          // Vector cycle; bus is sampled on its final edge
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (rdy_f) begin
            state <= IAC_IDLE;
            acknowledge_cycle_n <= 1'b1;
          end
        end
        default: begin
          state <= IAC_IDLE;
          acknowledge_cycle_n <= 1'b1;
        end
      endcase
    end
  end

  // Scope trigger spans both cycles when acknowledge sync is chosen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scope_trig_n <= 1'b1;
    end else if (seq_start && acknowledge_cycle_sync_sel) begin
      scope_trig_n <= 1'b0;
    end else if (seq_last) begin
      scope_trig_n <= 1'b1;
    end
  end

  // Captures; a capture wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vector <= IAC_VEC_RESET;
      cascade <= IAC_CASC_RESET;
    end else if (seq_last) begin
      // Bus values are stable while ready is confirmed, so no resync here
      vector <= tgt_bus.data[7:0];
      cascade <= tgt_bus.addr;
    end else if (wr_enable && host_cmd.wdata == IAC_ENABLE_VALUE) begin
      vector <= IAC_VEC_RESET;
      cascade <= IAC_CASC_RESET;
    end
  end

  // Enable and arming flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_en <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (wr_enable) begin
        // Any other value written turns interrupts off
        int_en <= host_cmd.wdata == IAC_ENABLE_VALUE;
      end
      if (seq_last) begin
        // Disarm wins, so a fresh vector is overwritten only by a forced sequence
        armed <= 1'b0;
      end else if (rd_rearm || (wr_enable && host_cmd.wdata == IAC_ENABLE_VALUE)) begin
        armed <= 1'b1;
      end
    end
  end

  // Pending-vector flag; a capture wins over a clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pending_vector_flag <= 1'b0;
    end else if (seq_last) begin
      pending_vector_flag <= 1'b1;
    end else if (rd_rearm || (wr_enable && host_cmd.wdata == IAC_ENABLE_VALUE)) begin
      pending_vector_flag <= 1'b0;
    end
  end

  // Force and loop requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      force_pend <= 1'b0;
      loop_on <= 1'b0;
    end else begin
      if (rd_force) begin
        force_pend <= 1'b1;
      end else if (seq_start) begin
        force_pend <= 1'b0;
      end
      // Loop runs until the host makes any other access
      if (rd_loop) begin
        loop_on <= 1'b1;
      end else if (req_take) begin
        loop_on <= 1'b0;
      end
    end
  end

  // Host answers: immediate for plain accesses, after capture for force reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_ack <= 1'b0;
      host_rdata <= IAC_RDATA_NONE;
      ack_wait <= 1'b0;
    end else begin
      host_ack <= 1'b0;
      if (ack_wait && seq_last) begin
        // Return the byte caught in this very cycle
        host_ack <= 1'b1;
        host_rdata <= {8'h00, tgt_bus.data[7:0]};
        ack_wait <= 1'b0;
      end else if (rd_force) begin
        ack_wait <= 1'b1;
      end else if (req_take) begin
        host_ack <= 1'b1;
        if (rd_rearm || rd_peek) begin
          host_rdata <= {8'h00, vector};
        end else if (rd_casc_lo) begin
          host_rdata <= cascade[15:0];
        end else if (rd_casc_hi) begin
          host_rdata <= {8'h00, cascade[23:16]};
        end else begin
          host_rdata <= IAC_RDATA_NONE;
        end
      end
    end
  end

  // Interrupt path to the pod processor and handler choice
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_to_cpu <= 1'b0;
      target_handler_sel <= 1'b0;
    end else begin
      irq_to_cpu <= int_en && armed && irq_f;
      // Target service routines only in emulation run
      target_handler_sel <= emulation_run_mode;
    end
  end

  // Checks
  property p_enable_clears;
    @(posedge clk_sys) disable iff (rst)
    (wr_enable && host_cmd.wdata == IAC_ENABLE_VALUE && !seq_last)
      |=> !pending_vector_flag && vector == IAC_VEC_RESET && cascade == IAC_CASC_RESET;
  endproperty
  a_enable_clears: assert property (p_enable_clears) else $error("enable write did not clear");

  property p_rearm_read;
    @(posedge clk_sys) disable iff (rst)
    (rd_rearm && !seq_last) |=> host_ack && armed && !pending_vector_flag
      && host_rdata[7:0] == $past(vector);
  endproperty
  a_rearm_read: assert property (p_rearm_read) else $error("rearm read wrong");

  property p_peek_read;
    @(posedge clk_sys) disable iff (rst)
    (rd_peek && !seq_last && !rd_rearm) |=> armed == $past(armed)
      && pending_vector_flag == $past(pending_vector_flag) && host_rdata[7:0] == $past(vector);
  endproperty
  a_peek_read: assert property (p_peek_read) else $error("peek read changed state");

  property p_block_after_ack;
    @(posedge clk_sys) disable iff (rst)
    seq_last |=> !armed ##1 !irq_to_cpu;
  endproperty
  a_block_after_ack: assert property (p_block_after_ack) else $error("not blocked");

  property p_capture;
    @(posedge clk_sys) disable iff (rst)
    seq_last |=> vector == $past(tgt_bus.data[7:0]) && cascade == $past(tgt_bus.addr);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed bus values");

  property p_cascade_read;
    @(posedge clk_sys) disable iff (rst)
    rd_casc_lo |=> host_ack && host_rdata == $past(cascade[15:0])
      && pending_vector_flag == $past(pending_vector_flag) || $past(seq_last);
  endproperty
  a_cascade_read: assert property (p_cascade_read) else $error("cascade read wrong");

  property p_force_starts;
    @(posedge clk_sys) disable iff (rst)
    (rd_force && state == IAC_IDLE) |=> ##1 state == IAC_CYC1 && !acknowledge_cycle_n;
  endproperty
  a_force_starts: assert property (p_force_starts) else $error("force did not start");

  property p_two_cycles;
    @(posedge clk_sys) disable iff (rst)
    (state == IAC_GAP && wait_cnt == 4'h0 && !rdy_f)
      |=> state == IAC_CYC2 && !acknowledge_cycle_n;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("second cycle missing");

  property p_scope;
    @(posedge clk_sys) disable iff (rst)
    (seq_start && acknowledge_cycle_sync_sel) |=> !scope_trig_n until_with (!acknowledge_cycle_n);
  endproperty
  a_scope: assert property (p_scope) else $error("scope trigger not low");

  property p_scope_end;
    @(posedge clk_sys) disable iff (rst)
    seq_last |=> scope_trig_n && acknowledge_cycle_n;
  endproperty
  a_scope_end: assert property (p_scope_end) else $error("scope trigger stayed low");

endmodule : iac_unit

// File: bench/iac_tgt_model.sv
// Target board model: interrupt controller answering acknowledge cycles
`timescale 1ns/1ps
module iac_tgt_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Answer settings from the bench
  input wire logic [7:0] vec,
  input wire logic [23:0] casc,
  input wire logic [3:0] delay,
  // Pod pins
  input wire logic acknowledge_cycle_n,
  output logic tgt_ready_n,
  output iac_pkg::iac_tbus_t tgt_bus
);
  import iac_pkg::*;
  logic [3:0] cnt; // Clocks into the current cycle
  logic second; // Next cycle delivers the vector
  logic ack_q; // Strobe level at the last edge
  // Answer each acknowledge cycle after a chosen number of clocks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 4'h0;
      second <= 1'b0;
      tgt_ready_n <= 1'b1;
      tgt_bus <= '0;
    end else if (!acknowledge_cycle_n) begin
      cnt <= cnt + 4'h1;
      // Ready held low until the strobe ends, so the synchroniser sees it
      tgt_ready_n <= (cnt < delay);
      // First cycle shows the inverse byte, so a wrong capture shows up
      tgt_bus <= second ? {8'h00, vec, casc} : {8'h00, ~vec, casc};
    end else begin
      cnt <= 4'h0;
      tgt_ready_n <= 1'b1;
      // Released bus keeps changing instead of holding a stale value
      tgt_bus <= iac_tbus_t'(~tgt_bus);
      if (!ack_q) begin
        second <= ~second;
      end
    end
  end
  // Strobe history for cycle counting
  always_ff @(posedge clk_sys) begin
    ack_q <= rst | acknowledge_cycle_n;
  end
endmodule : iac_tgt_model

// File: bench/iac_unit_bench.sv
// Self-checking bench for the interrupt acknowledge capture unit
`timescale 1ns/1ps
module iac_unit_bench;
  import iac_pkg::*;
  logic clk_sys = 1'b0; // System clock
  logic rst = 1'b1; // Synchronous reset
  logic host_req = 1'b0; // Host strobe
  iac_hreq_t host_cmd = '0; // Host command
  logic host_ack; // Host answer
  logic [15:0] host_rdata; // Host read data
  logic irq_in = 1'b0; // Target request pin
  logic ready_n; // Target ready
  iac_tbus_t tbus; // Target bus
  logic ack_n; // Acknowledge strobe
  logic sync_sel = 1'b0; // Scope sync select
  logic emu = 1'b0; // Emulation run
  logic scope_n; // Scope trigger
  logic irq_cpu; // Request to processor
  logic hsel; // Handler select
  logic pend; // Pending vector flag
  logic [7:0] vec = 8'h00; // Model vector
  logic [23:0] casc = 24'h000000; // Model cascade address
  logic [3:0] delay = 4'h1; // Model ready delay
  logic [15:0] rd; // Last read value
  logic prev_ack = 1'b1; // Strobe at last sample
  int falls = 0; // Acknowledge cycles seen
  int scope_bad = 0; // Trigger high inside a cycle
  int error_cnt = 0; // Mismatches
  int checks = 0; // Comparisons
  int i; // Wait counter

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  iac_unit DUT (.clk_sys(clk_sys), .rst(rst), .host_req(host_req), .host_cmd(host_cmd),
    .host_ack(host_ack), .host_rdata(host_rdata), .interrupt_request_input(irq_in),
    .tgt_ready_n(ready_n), .tgt_bus(tbus), .acknowledge_cycle_n(ack_n),
    .acknowledge_cycle_sync_sel(sync_sel), .emulation_run_mode(emu), .scope_trig_n(scope_n),
    .irq_to_cpu(irq_cpu), .target_handler_sel(hsel), .pending_vector_flag(pend));

  iac_tgt_model tgt (.clk_sys(clk_sys), .rst(rst), .vec(vec), .casc(casc), .delay(delay),
    .acknowledge_cycle_n(ack_n), .tgt_ready_n(ready_n), .tgt_bus(tbus));

  // Count acknowledge cycles and watch the trigger inside them
  always @(negedge clk_sys) begin
    if (prev_ack === 1'b1 && ack_n === 1'b0) begin
      falls++;
    end
    if (sync_sel && ack_n === 1'b0 && scope_n !== 1'b0) begin
      scope_bad++;
    end
    prev_ack = ack_n;
  end

  // Verdict and end of run
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // Compare one value
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One host access; only the function addresses control interrupts
  task automatic access(input logic wr, input logic [31:0] addr, input logic [15:0] wd);
    @(negedge clk_sys);
    host_req = 1'b1;
    host_cmd = '{wr, addr, wd};
    @(negedge clk_sys);
    host_req = 1'b0;
    // Forced reads wait on the target, so allow a long bound
    for (i = 0; i < 2000 && host_ack !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    rd = host_rdata;
    if (i == 2000) begin
      error_cnt++;
      print_verdict();
    end
  endtask : access

  // Read and compare
  task automatic rdc(input logic [31:0] addr, input logic [15:0] exp);
    access(1'b0, addr, 16'h0000);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rdc

  // Bounded wait for a captured vector
  task automatic wait_pend();
    for (i = 0; i < 500 && pend !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    check({23'h0, pend}, 24'h1);
  endtask : wait_pend

  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    // Reset state
    check({22'h0, pend, irq_cpu}, 24'h0);
    rdc(IAC_ADDR_VEC_PEEK, 16'h0000);
    rdc(IAC_ADDR_CASC_LOW, 16'h0000);
    $display("test reset done");
    // Request, capture, block, rearm
    vec = 8'h3c;
    casc = 24'hab1234;
    access(1'b1, IAC_ADDR_INT_ENABLE, IAC_ENABLE_VALUE);
    irq_in = 1'b1;
    wait_pend();
    rdc(IAC_ADDR_VEC_PEEK, 16'h003c);
    rdc(IAC_ADDR_CASC_LOW, 16'h1234);
    rdc(IAC_ADDR_CASC_HIGH, 16'h00ab);
    check({23'h0, pend}, 24'h1);
    vec = 8'h77;
    falls = 0;
    repeat (40) @(negedge clk_sys);
    check(24'(falls), 24'h0);
    rdc(IAC_ADDR_VEC_REARM, 16'h003c);
    check({23'h0, pend}, 24'h0);
    wait_pend();
    irq_in = 1'b0;
    rdc(IAC_ADDR_VEC_PEEK, 16'h0077);
    $display("test request done");
    // Enable write clears captures
    repeat (6) @(negedge clk_sys);
    access(1'b1, IAC_ADDR_INT_ENABLE, IAC_ENABLE_VALUE);
    check({23'h0, pend}, 24'h0);
    rdc(IAC_ADDR_VEC_PEEK, 16'h0000);
    rdc(IAC_ADDR_CASC_HIGH, 16'h0000);
    $display("test enable done");
    // Forced sequence with a slow target and scope sync
    sync_sel = 1'b1;
    delay = 4'h5;
    vec = 8'h5a;
    casc = 24'h0c0001;
    falls = 0;
    rdc(IAC_ADDR_FORCE_ONCE, 16'h005a);
    check(24'(falls), 24'h2);
    check(24'(scope_bad), 24'h0);
    check({23'h0, scope_n}, 24'h1);
    rdc(IAC_ADDR_CASC_LOW, 16'h0001);
    $display("test force done");
    // Looping force, then stop it with another access
    delay = 4'h1;
    falls = 0;
    rdc(IAC_ADDR_FORCE_LOOP, 16'h005a);
    repeat (100) @(negedge clk_sys);
    check(24'(falls > 3), 24'h1);
    rdc(IAC_ADDR_VEC_PEEK, 16'h005a);
    repeat (30) @(negedge clk_sys);
    falls = 0;
    repeat (40) @(negedge clk_sys);
    check(24'(falls), 24'h0);
    check(24'(scope_bad), 24'h0);
    $display("test loop done");
    // Handler choice and unmapped read
    emu = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({23'h0, hsel}, 24'h1);
    emu = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({23'h0, hsel}, 24'h0);
    rdc(32'hf000008a, IAC_RDATA_NONE);
    $display("test mode done");
    print_verdict();
  end
endmodule : iac_unit_bench
